// ### ric_top.sv
// Purpose: reference input conditioner, secondary loop mode control
// Assumes: one clock domain; composite pins and sel inputs asynchronous
// Notes: registers on avalon-mm, one wait state on every access
//
// Contract
// [R1] mode field: auto, free, holdover, locked
// [R2] loop powered down after reset
// [R3] auto mode re-evaluates on selection changes
// [R4] auto: free, locked when selected, else holdover
// [R5] free-run ignores all references
// [R6] locked follows selected input frequency
// [R7] average off: hold instantaneous integral value
// [R8] average on: hold averaged frequency
// [R9] output frequency clamped to hard limit
// [R10] composite violation flags, masked interrupt request
// [R11] software sets slow tone bit correctly
// [R12] four-bit field picks sync pin
// [R13] sync inputs three to fourteen, rate matched
// [R14] composite inputs fixed 8 kHz, bypass divider
// [R15] target rate codes, others reserved
// [R16] software bypasses divider for slow inputs
// [R17] high-rate prescaler divide 4, 5, bypass
// [R18] software bypasses integer divider for sync
// [R19] factor loaded low byte then high
// [R20] factor equals input over target minus one
// [R21] fractional divider 16-bit over 16-bit
// [R22] input quality monitored continuously
// [R23] loss after 1 ms low, hysteretic release
// [R24] loss raises interrupt, disqualifies input
//
// The register addresses and the Avalon-MM interface to the registers were chosen for this implementation.
module ric_top
  import ric_pkg::*;
#(
  parameter int unsigned LOS_COUNT = LOS_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // avalon-mm slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // composite inputs: amplitude comparators and structure checker
  input wire logic [1:0] composite_low_amp,
  input wire logic [1:0] composite_high_amp,
  input wire logic [1:0] composite_struct_bad,
  // secondary loop selection and integral path
  input wire logic sel_valid,
  input wire logic [3:0] sel_input,
  input wire logic [31:0] integral_freq,
  // outputs
  output logic int_req,
  output logic [1:0] secondary_loop_state,
  output logic [31:0] loop_freq,
  output logic [3:0] sync_pin_select,
  output logic [3:0] target_rate,
  output logic [1:0] high_rate_prescale,
  output logic [14:0] integer_divide_factor,
  output logic [31:0] frac_ratio,
  output logic [1:0] composite_disqualify
);
  localparam int unsigned LOSW = $clog2(LOS_COUNT + 1);

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] limit;
    logic [31:0] frac;
    logic [14:0] divf;
    logic [7:0] divlo;
    logic [13:0] incfg;
    logic [3:0] mask;
    logic [1:0] viol;
    logic [1:0] lost;
    logic [LOSW-1:0] cnt0;
    logic [LOSW-1:0] cnt1;
    logic [1:0] s1_lo, s2_lo, s1_hi, s2_hi, s1_bad, s2_bad;
    logic s1_v, s2_v;
    logic [3:0] s1_sel, s2_sel;
    logic prev_v;
    logic [3:0] prev_sel;
    ric_state_t st;
    logic [31:0] hold_freq;
    logic [31:0] avg_freq;
    logic [31:0] freq;
    logic ack;
    logic [31:0] rdata;
    logic irq;
    // registered output decode
    logic [3:0] rate;
    logic [1:0] pres;
    logic [14:0] divo;
  } ric_s_t;

  ric_s_t s_reg, s_next;

  logic [2:0] mode;
  logic pdn;
  logic [31:0] raw_freq;
  logic [31:0] lim_lo;
  logic [31:0] lim_hi;
  logic [3:0] port_id;
  logic composite_sel;
  logic [33:0] avg_sum;

  always_comb begin
    s_next = s_reg;
    mode = s_reg.ctrl[CTRL_MODE_LSB +: 3];
    pdn = s_reg.ctrl[CTRL_PDN_BIT];
    port_id = s_reg.incfg[3:0];
    composite_sel = (port_id < 4'h2);
    // input synchronisers, first stage read only by second
    s_next.s1_lo = composite_low_amp;
    s_next.s2_lo = s_reg.s1_lo;
    s_next.s1_hi = composite_high_amp;
    s_next.s2_hi = s_reg.s1_hi;
    s_next.s1_bad = composite_struct_bad;
    s_next.s2_bad = s_reg.s1_bad;
    s_next.s1_v = sel_valid;
    s_next.s2_v = s_reg.s1_v;
    s_next.s1_sel = sel_input;
    s_next.s2_sel = s_reg.s1_sel;
    s_next.prev_v = s_reg.s2_v;
    s_next.prev_sel = s_reg.s2_sel;

    // loss detect: counter runs while amplitude low [R22] [R23]
    if (s_reg.s2_lo[0]) begin
      if (s_reg.cnt0 != LOSW'(LOS_COUNT)) s_next.cnt0 = s_reg.cnt0 + 1'b1;
    end else begin
      s_next.cnt0 = '0;
    end
    if (s_reg.s2_lo[1]) begin
      if (s_reg.cnt1 != LOSW'(LOS_COUNT)) s_next.cnt1 = s_reg.cnt1 + 1'b1;
    end else begin
      s_next.cnt1 = '0;
    end
    // release only above the higher threshold; in between it holds
    if (s_reg.cnt0 == LOSW'(LOS_COUNT)) s_next.lost[0] = 1'b1; // [R23]
    else if (s_reg.s2_hi[0]) s_next.lost[0] = 1'b0;
    if (s_reg.cnt1 == LOSW'(LOS_COUNT)) s_next.lost[1] = 1'b1; // [R23]
    else if (s_reg.s2_hi[1]) s_next.lost[1] = 1'b0;

    // holdover average: first-order filter, narrow bandwidth [R8]
    // arithmetic shift keeps negative offsets; carries above bit 31 are dropped
    avg_sum = {2'h0, s_reg.avg_freq} - {2'h0, 32'($signed(s_reg.avg_freq) >>> AVG_SHIFT)}
      + {2'h0, 32'($signed(integral_freq) >>> AVG_SHIFT)};
    // loop state machine [R1] [R3] [R4]
    if (pdn) begin
      s_next.st = RIC_FREE; // [R2]
    end else begin
      case (mode)
        MODE_FREE: s_next.st = RIC_FREE;
        MODE_HOLD: s_next.st = RIC_HOLD;
        MODE_LOCK: s_next.st = RIC_LOCK;
        MODE_AUTO: begin
          // a changed selection is a re-evaluation point [R3]
          if (s_reg.s2_v) s_next.st = RIC_LOCK; // [R4]
          else if (s_reg.st != RIC_FREE || s_reg.prev_v) s_next.st = RIC_HOLD;
          else s_next.st = s_reg.st;
        end
        default: s_next.st = s_reg.st;
      endcase
    end
    if (s_reg.st == RIC_LOCK) begin
      s_next.hold_freq = integral_freq; // [R7]
      s_next.avg_freq = avg_sum[31:0]; // [R8]
    end
    case (s_reg.st)
      RIC_LOCK: raw_freq = integral_freq; // [R6]
      RIC_HOLD: raw_freq = s_reg.ctrl[CTRL_AVG_BIT] ? s_reg.avg_freq : s_reg.hold_freq;
      default: raw_freq = 32'h0; // [R5]
    endcase
    lim_hi = {16'h0, s_reg.limit[15:0]};
    lim_lo = 32'(-$signed(lim_hi));
    if (pdn) s_next.freq = 32'h0;
    else if ($signed(raw_freq) > $signed(lim_hi)) s_next.freq = lim_hi; // [R9]
    else if ($signed(raw_freq) < $signed(lim_lo)) s_next.freq = lim_lo; // [R9]
    else s_next.freq = raw_freq;

    // violation flags; set beats a clearing write [R10]
    if (write && s_reg.ack && address == OFF_STATUS) begin
      s_next.viol = s_reg.viol & ~writedata[1:0];
    end
    s_next.viol = s_next.viol | s_reg.s2_bad;
    s_next.irq = |((s_reg.viol & s_reg.mask[1:0]) | (s_reg.lost & s_reg.mask[3:2])); // [R10] [R24]

    // avalon slave: one wait cycle then ack
    s_next.ack = (read || write) && !s_reg.ack;
    s_next.rdata = 32'h0;
    // writes land only on the edge that sees waitrequest low
    if (write && s_reg.ack) begin
      case (address)
        OFF_CTRL: s_next.ctrl = {26'h0, writedata[5:0]};
        OFF_MASK: s_next.mask = writedata[3:0];
        OFF_LIMIT: s_next.limit = {16'h0, writedata[15:0]};
        OFF_DIVLO: s_next.divlo = writedata[7:0]; // [R19]
        OFF_DIVHI: s_next.divf = {writedata[6:0], s_reg.divlo}; // [R19] [R20]
        OFF_FRAC: s_next.frac = writedata; // [R21]
        OFF_INCFG: s_next.incfg = writedata[13:0]; // [R12]
        default: s_next.rdata = 32'h0;
      endcase
    end
    if (read && !s_reg.ack) begin
      case (address)
        OFF_CTRL: s_next.rdata = s_reg.ctrl;
        OFF_STATUS: s_next.rdata = {26'h0, s_reg.st, s_reg.lost, s_reg.viol};
        OFF_MASK: s_next.rdata = {28'h0, s_reg.mask};
        OFF_LIMIT: s_next.rdata = s_reg.limit;
        OFF_DIVLO: s_next.rdata = {24'h0, s_reg.divlo};
        OFF_DIVHI: s_next.rdata = {17'h0, s_reg.divf};
        OFF_FRAC: s_next.rdata = s_reg.frac;
        OFF_INCFG: s_next.rdata = {18'h0, s_reg.incfg};
        OFF_FREQ: s_next.rdata = s_reg.freq;
        default: s_next.rdata = 32'h0;
      endcase
    end

    // decode from the next configuration so outputs land with the write;
    // composite inputs ignore rate, prescale and factor fields [R14]
    if (s_next.incfg[3:0] < 4'h2) begin
      s_next.rate = RATE_8K; // [R14]
      s_next.pres = PRE_BYPASS;
      s_next.divo = 15'h0;
    end else begin
      s_next.rate = s_next.incfg[7:4]; // [R15] reserved codes pass as written
      s_next.divo = s_next.divf; // [R20]
      if (s_next.incfg[3:0] <= 4'h7) s_next.pres = s_next.incfg[9:8]; // [R17]
      else s_next.pres = PRE_BYPASS;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '0;
      s_reg.ctrl <= CTRL_RESET; // [R2]
      s_reg.limit <= LIMIT_RESET;
      s_reg.st <= RIC_FREE; // [R4]
    end else begin
      s_reg <= s_next;
    end
  end

  // decoded outputs are registered beside the configuration they follow
  assign target_rate = s_reg.rate; // [R14] [R15]
  assign high_rate_prescale = s_reg.pres; // [R17]
  assign sync_pin_select = s_reg.incfg[13:10];
  assign integer_divide_factor = s_reg.divo; // [R14]
  assign frac_ratio = s_reg.frac;
  assign composite_disqualify = s_reg.lost; // [R24]
  assign secondary_loop_state = s_reg.st;
  assign loop_freq = s_reg.freq;
  assign int_req = s_reg.irq;
  assign readdata = s_reg.rdata;
  assign waitrequest = !s_reg.ack;

  sequence ric_low_run_s;
    s_reg.cnt0 == LOSW'(LOS_COUNT);
  endsequence
  los_set_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R23]
    ric_low_run_s |=> s_reg.lost[0]) else $error("loss not declared");
  pdn_free_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R2]
    s_reg.ctrl[CTRL_PDN_BIT] |=> s_reg.st == RIC_FREE) else $error("down loop left free");
  auto_lock_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R4]
    (!pdn && mode == MODE_AUTO && s_reg.s2_v) |=> s_reg.st == RIC_LOCK)
    else $error("auto lock missed");
  force_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R1]
    (!pdn && mode == MODE_HOLD) |=> s_reg.st == RIC_HOLD) else $error("forced hold missed");
  free_zero_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R5]
    (s_reg.st == RIC_FREE) |=> s_reg.freq == 32'h0) else $error("free run not zero");
  clamp_hi_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R9]
    !($signed(s_reg.freq) > $signed({16'h0, $past(s_reg.limit[15:0])})))
    else $error("frequency over limit");
  viol_irq_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R10]
    (s_reg.viol[0] && s_reg.mask[0]) |=> int_req) else $error("violation irq missing");
  comp_rate_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R14]
    composite_sel |-> (target_rate == RATE_8K && integer_divide_factor == 15'h0))
    else $error("composite not fixed");
  bus_ack_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    ((read || write) && waitrequest) |=> !waitrequest) else $error("no bus answer");

  // loss, hysteresis, violation and interrupt paths
  sequence ric_low_run_b_s;
    s_reg.cnt1 == LOSW'(LOS_COUNT);
  endsequence
  los_set_b_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R23]
    ric_low_run_b_s |=> s_reg.lost[1])
    else $error("loss b not declared");
  los_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R23]
    (s_reg.lost[0] && !s_reg.s2_hi[0]) |=> s_reg.lost[0])
    else $error("loss released early");
  los_release_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R23]
    (s_reg.lost[0] && s_reg.s2_hi[0] && s_reg.cnt0 != LOSW'(LOS_COUNT)) |=> !s_reg.lost[0])
    else $error("loss not released");
  los_irq_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R24]
    (s_reg.lost[1] && s_reg.mask[3]) |=> int_req)
    else $error("loss irq missing");
  viol_set_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R10]
    s_reg.s2_bad[0] |=> s_reg.viol[0])
    else $error("violation not flagged");
  irq_quiet_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R10]
    ((s_reg.viol & s_reg.mask[1:0]) == 2'h0 && (s_reg.lost & s_reg.mask[3:2]) == 2'h0)
    |=> !int_req) else $error("unmasked irq raised");

  // mode control, output frequency and prescale decode
  force_free_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R1]
    (!pdn && mode == MODE_FREE) |=> s_reg.st == RIC_FREE)
    else $error("forced free missed");
  force_lock_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R1]
    (!pdn && mode == MODE_LOCK) |=> s_reg.st == RIC_LOCK)
    else $error("forced lock missed");
  sequence ric_lock_drop_s;
    (s_reg.st == RIC_LOCK && s_reg.s2_v) ##1 (!pdn && mode == MODE_AUTO && !s_reg.s2_v);
  endsequence
  lock_drop_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R4]
    ric_lock_drop_s |=> s_reg.st == RIC_HOLD)
    else $error("holdover not entered");
  auto_reselect_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R3]
    (!pdn && mode == MODE_AUTO && s_reg.s2_v && s_reg.s2_sel != s_reg.prev_sel)
    |=> s_reg.st == RIC_LOCK) else $error("reselection not locked");
  lock_follow_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R6]
    (s_reg.st == RIC_LOCK && !pdn && $signed(integral_freq) <= $signed(lim_hi)
      && $signed(integral_freq) >= $signed(lim_lo)) |=> loop_freq == $past(integral_freq))
    else $error("locked output not following");
  hold_keep_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R7]
    (s_reg.st != RIC_LOCK) |=> $stable(s_reg.hold_freq))
    else $error("held value moved");
  avg_keep_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R8]
    (s_reg.st != RIC_LOCK) |=> $stable(s_reg.avg_freq))
    else $error("averaged value moved");
  pdn_zero_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R2]
    pdn |=> s_reg.freq == 32'h0)
    else $error("down loop output not zero");
  clamp_lo_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R9]
    !($signed(s_reg.freq) < -$signed({16'h0, $past(s_reg.limit[15:0])})))
    else $error("frequency under limit");
  dec_pres_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R17]
    (s_reg.incfg[3:0] > 4'h7) |-> high_rate_prescale == PRE_BYPASS)
    else $error("prescale on plain input");

  // bus protocol
  bus_stand_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    !waitrequest |=> waitrequest)
    else $error("answer stood too long");
  rdata_idle_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    waitrequest |-> readdata == 32'h0)
    else $error("read data outside answer");
endmodule

// ### ric_pkg.sv
// Purpose: constants and types for the reference input conditioner
// Assumes: avalon-mm word registers, 25 MHz system clock
// Notes: offsets are byte addresses of 32-bit words
package ric_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned LOS_TIME_US = 1000;
  localparam int unsigned LOS_CYCLES = (LOS_TIME_US * (CLK_HZ / 1000000));
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_MASK = 8'h08;
  localparam logic [7:0] OFF_LIMIT = 8'h0c;
  localparam logic [7:0] OFF_DIVLO = 8'h10;
  localparam logic [7:0] OFF_DIVHI = 8'h14;
  localparam logic [7:0] OFF_FRAC = 8'h18;
  localparam logic [7:0] OFF_INCFG = 8'h1c;
  localparam logic [7:0] OFF_FREQ = 8'h20;
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_PDN_BIT = 3;
  localparam int unsigned CTRL_AVG_BIT = 4;
  localparam int unsigned CTRL_SLOW_BIT = 5;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0008;
  localparam logic [31:0] LIMIT_RESET = 32'h0000_ffff;
  localparam logic [2:0] MODE_AUTO = 3'h0;
  localparam logic [2:0] MODE_FREE = 3'h1;
  localparam logic [2:0] MODE_HOLD = 3'h2;
  localparam logic [2:0] MODE_LOCK = 3'h4;
  localparam logic [3:0] RATE_8K = 4'h0;
  localparam logic [3:0] RATE_T1E1 = 4'h1;
  localparam logic [3:0] RATE_648M = 4'h2;
  localparam logic [3:0] RATE_2K = 4'h9;
  localparam logic [3:0] RATE_4K = 4'ha;
  localparam logic [3:0] RATE_1PPS = 4'hb;
  localparam logic [3:0] RATE_625M = 4'hc;
  localparam logic [1:0] PRE_BYPASS = 2'h0;
  localparam logic [1:0] PRE_DIV4 = 2'h1;
  localparam logic [1:0] PRE_DIV5 = 2'h2;
  localparam int unsigned AVG_SHIFT = 10;
  typedef enum logic [1:0] {RIC_FREE, RIC_LOCK, RIC_HOLD} ric_state_t;
endpackage

// ### ric_ref_model.sv
// Purpose: far-side model of composite sources and loop selection
// Assumes: bench commands land one edge later
// Notes: a released select line toggles so stale values never match
module ric_ref_model (
  // commands from the bench
  input wire logic clk_sys,
  input wire logic [1:0] drop,
  input wire logic [1:0] garble,
  input wire logic pick,
  input wire logic [3:0] pin,
  input wire logic [31:0] freq,
  // toward the conditioner
  output logic [1:0] composite_low_amp,
  output logic [1:0] composite_high_amp,
  output logic [1:0] composite_struct_bad,
  output logic sel_valid,
  output logic [3:0] sel_input,
  output logic [31:0] integral_freq
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    composite_low_amp = 2'h0;
    composite_high_amp = 2'h3;
    composite_struct_bad = 2'h0;
    sel_valid = 1'h0;
    sel_input = 4'h0;
    integral_freq = 32'h0;
  end
  always @(posedge clk_sys) begin
    composite_low_amp <= drop;
    composite_high_amp <= ~drop;
    composite_struct_bad <= garble;
    sel_valid <= pick;
    sel_input <= pick ? pin : ~sel_input;
    integral_freq <= freq;
  end
endmodule

// ### tb_reference_input_conditioner.sv
// Purpose: self-checking bench for the reference input conditioner
// Assumes: loss count shortened to 20 cycles
// Notes: slow outputs are polled under a bound, then compared
module tb_reference_input_conditioner
  import ric_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LOSN = 20;
  logic clk_sys = 1'h0, rstn = 1'h0, read = 1'h0, write = 1'h0, pick = 1'h0;
  logic sel_valid, waitrequest, int_req;
  logic [7:0] address = 8'h0;
  logic [31:0] writedata = 32'h0, freq = 32'h0, readdata, loop_freq, frac_ratio, rd, ifq;
  logic [1:0] drop = 2'h0, garble = 2'h0, low_a, high_a, bad, state, pres, disq;
  logic [3:0] pin = 4'h3, sel_input, sync_pin, rate;
  logic [14:0] divf;
  logic [3:0] rates [7] = '{4'h0, 4'h1, 4'h2, 4'h9, 4'ha, 4'hb, 4'hc};
  int seed = 53, n_mismatch = 0, total_checks = 0;
  always #20 clk_sys = ~clk_sys;
  ric_top #(.LOS_COUNT(LOSN)) dut (.clk_sys(clk_sys), .rstn(rstn), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .composite_low_amp(low_a), .composite_high_amp(high_a),
    .composite_struct_bad(bad), .sel_valid(sel_valid), .sel_input(sel_input),
    .integral_freq(ifq), .int_req(int_req), .secondary_loop_state(state),
    .loop_freq(loop_freq), .sync_pin_select(sync_pin), .target_rate(rate),
    .high_rate_prescale(pres), .integer_divide_factor(divf), .frac_ratio(frac_ratio),
    .composite_disqualify(disq));
  ric_ref_model src (.clk_sys(clk_sys), .drop(drop), .garble(garble), .pick(pick), .pin(pin),
    .freq(freq), .composite_low_amp(low_a), .composite_high_amp(high_a),
    .composite_struct_bad(bad), .sel_valid(sel_valid), .sel_input(sel_input),
    .integral_freq(ifq));
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // request held until waitrequest is seen low; the watchdog ends a hang
  task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= ~wr;
    do @(posedge clk_sys); while (waitrequest !== 1'h0);
    rd = readdata;
    write <= 1'h0;
    read <= 1'h0;
    @(posedge clk_sys);
  endtask
  function automatic logic [31:0] probe(int k);
    case (k)
      0: return {30'h0, state};
      1: return loop_freq;
      2: return {31'h0, int_req};
      default: return {30'h0, disq};
    endcase
  endfunction
  task automatic see(int k, logic [31:0] exp, string what);
    int n;
    n = 0;
    while (probe(k) !== exp && n < 60) begin
      @(posedge clk_sys);
      n++;
    end
    chk(what, exp, probe(k));
  endtask
  // model: output word is the integral value clamped to +/- limit
  function automatic logic [31:0] clampm(int f, int lim);
    return (f > lim) ? lim : ((f < -lim) ? -lim : f);
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk_sys);
    n_mismatch++;
    summarize();
  end
  initial begin
    logic [31:0] f1;
    int m [4] = '{1, 2, 4, 3};
    int s [4] = '{0, 2, 1, 1};
    repeat (20) @(posedge clk_sys);
    rstn <= 1'h1;
    @(posedge clk_sys);
    bus(1'h0, OFF_CTRL, 32'h0);
    chk("ctrl", CTRL_RESET, rd);
    bus(1'h0, OFF_LIMIT, 32'h0);
    chk("limit", LIMIT_RESET, rd);
    bus(1'h0, OFF_MASK, 32'h0);
    chk("mask", 32'h0, rd);
    bus(1'h0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, rd);
    pick <= 1'h1;
    repeat (10) @(posedge clk_sys);
    chk("state", RIC_FREE, state);
    bus(1'h1, OFF_CTRL, 32'h20);
    f1 = $random(seed) & 32'h7fff;
    freq <= f1;
    see(0, RIC_LOCK, "state");
    see(1, f1, "freq");
    pick <= 1'h0;
    see(0, RIC_HOLD, "state");
    freq <= $random(seed);
    repeat (10) @(posedge clk_sys);
    chk("freq", f1, loop_freq);
    pick <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      bus(1'h1, OFF_CTRL, m[i]);
      see(0, s[i], "state");
    end
    bus(1'h1, OFF_LIMIT, 32'h100);
    freq <= 32'h12345;
    see(1, clampm(32'h12345, 256), "freq");
    freq <= -32'sh5000;
    see(1, clampm(-20480, 256), "freq");
    bus(1'h1, OFF_CTRL, 32'h1);
    see(1, 32'h0, "freq");
    garble <= 2'h1;
    @(posedge clk_sys);
    garble <= 2'h0;
    repeat (6) @(posedge clk_sys);
    bus(1'h0, OFF_STATUS, 32'h0);
    chk("viol", 32'h1, rd & 32'h3);
    chk("irq", 32'h0, int_req);
    bus(1'h1, OFF_MASK, 32'h1);
    see(2, 32'h1, "irq");
    bus(1'h1, OFF_STATUS, 32'h1);
    bus(1'h1, OFF_MASK, 32'hc);
    see(2, 32'h0, "irq");
    drop <= 2'h3;
    repeat (LOSN / 2) @(posedge clk_sys);
    chk("lost", 32'h0, disq);
    see(3, 32'h3, "lost");
    see(2, 32'h1, "irq");
    drop <= 2'h0;
    see(3, 32'h0, "lost");
    bus(1'h1, OFF_INCFG, 32'h3);
    bus(1'h1, OFF_DIVLO, 32'd2429 & 32'hff);
    bus(1'h1, OFF_DIVHI, 32'd2429 >> 8);
    chk("divide", 19440000 / 8000 - 1, divf);
    f1 = $random(seed);
    bus(1'h1, OFF_FRAC, f1);
    chk("frac", f1, frac_ratio);
    foreach (rates[i]) begin
      bus(1'h1, OFF_INCFG, {18'h0, 4'(i + 3), 2'(i % 3), rates[i], 4'h3});
      chk("rate", rates[i], rate);
      chk("prescale", i % 3, pres);
      chk("sync", i + 3, sync_pin);
    end
    bus(1'h1, OFF_INCFG, 32'h0000_0110);
    chk("rate", RATE_8K, rate);
    chk("prescale", PRE_BYPASS, pres);
    bus(1'h1, OFF_INCFG, 32'h0000_0219);
    chk("prescale", PRE_BYPASS, pres);
    summarize();
  end
endmodule
